// File: verilog/ipm_pkg.sv
// package of constants and types for the interrupt and power mode controller
package ipm_pkg;
    localparam logic [31:0] IPM_MISC_ADDR = 32'h0000_0020;
    localparam logic [31:0] IPM_CTRL_ADDR = 32'h0000_0024;
    localparam logic [31:0] IPM_STAT_ADDR = 32'h0000_0028;
    localparam logic [7:0] IPM_MISC_RESET = 8'h00;
    localparam int IPM_POL_HI_POS = 6;
    localparam int IPM_CLKOUT_POS = 5;
    localparam int IPM_POL_LO_POS = 3;
    localparam int IPM_DIV_POS = 1;
    localparam int IPM_SLOW_POS = 0;
    localparam int IPM_STAB_CYCLES = 4096;
    localparam logic [15:0] IPM_VEC_RESET = 16'hFFFE;
    localparam logic [15:0] IPM_VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] IPM_VEC_EXT0 = 16'hFFF6;
    localparam logic [15:0] IPM_VEC_SPI = 16'hFFEC;
    localparam logic [15:0] IPM_VEC_TIMA = 16'hFFEA;
    localparam logic [15:0] IPM_VEC_TIMB = 16'hFFE8;
    localparam logic [15:0] IPM_VEC_SCI = 16'hFFE6;
    localparam logic [1:0] IPM_POL_FALL_LOW = 2'h0;
    localparam logic [1:0] IPM_POL_FALL = 2'h2;
    localparam logic [1:0] IPM_POL_RISE = 2'h1;
    localparam logic [1:0] IPM_POL_BOTH = 2'h3;
    typedef enum logic [2:0] {IPM_RUN, IPM_STACK, IPM_WAIT, IPM_HALT, IPM_STAB} ipm_state_t;
endpackage : ipm_pkg

// File: verilog/ipm_ctrl.sv
// interrupt priority, vectoring and power mode controller with ahb-lite registers
`timescale 1ns/1ns
`default_nettype none
module ipm_ctrl
    import ipm_pkg::*;
#(
    parameter int STAB_COUNT = IPM_STAB_CYCLES
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // core sequencer
    input wire logic instr_end,
    input wire logic trap_instr,
    input wire logic irq_return_instr,
    input wire logic wait_for_irq_instr,
    input wire logic halt_instr,
    input wire logic watchdog_enabled,
    input wire logic stack_done,
    output logic condition_code_reg_i,
    output logic irq_take,
    output logic [15:0] irq_vector,
    output logic core_stall,
    output logic push_context,
    output logic watchdog_reset,
    // external pin groups (pins configured as interrupt inputs)
    input wire logic [3:0] ext_group_zero,
    input wire logic [2:0] ext_group_one,
    input wire logic [3:0] ext_group_two,
    input wire logic [3:0] ext_group_three,
    // peripheral flags and enables: spi, timer a, timer b, sci
    input wire logic [1:0] spi_flags,
    input wire logic [1:0] spi_enables,
    input wire logic [4:0] tima_flags,
    input wire logic [4:0] tima_enables,
    input wire logic [4:0] timb_flags,
    input wire logic [4:0] timb_enables,
    input wire logic [4:0] sci_flags,
    input wire logic [4:0] sci_enables,
    // clocks and clock output pin
    input wire logic osc_clk_level,
    output logic osc_enable,
    output logic cpu_clk_tick,
    output logic cpu_clk_level,
    output logic port_f_pin_zero_out,
    output logic port_f_pin_zero_oe_n
);
    localparam int SCW = $clog2(STAB_COUNT + 1);

    ipm_state_t state;
    logic [7:0] misc;
    logic [3:0] ext_pend;
    logic [3:0] ext_prev;
    logic [SCW-1:0] stab_cnt;
    logic [4:0] div_cnt;
    logic wake_by_reset;
    logic ap_valid;
    logic ap_write;
    logic [31:0] ap_addr;
    logic [3:0] ext_level;
    logic [3:0] per_req;
    logic [3:0] ext_cond;
    logic [3:0] ext_edge;
    logic [3:0] pol_clear;
    logic [7:0] next_misc;
    logic [4:0] div_max;
    logic mask;
    logic any_ext;
    logic any_per;

    // group pins anded; the active-low sense is folded into the decode below,
    // so any pin held low blocks the other pins of its group
    assign ext_level = {&ext_group_three, &ext_group_two, &ext_group_one, &ext_group_zero};
    // peripheral flags gated by their own enables each cycle
    assign per_req = {|(sci_flags & sci_enables), |(timb_flags & timb_enables),
                      |(tima_flags & tima_enables), |(spi_flags & spi_enables)};
    assign mask = condition_code_reg_i;

    always_comb begin
        for (int g = 0; g < 4; g++) begin
            logic [1:0] pol;
            pol = (g < 2) ? misc[IPM_POL_LO_POS +: 2] : misc[IPM_POL_HI_POS +: 2];
            ext_edge[g] = 1'b0;
            ext_cond[g] = 1'b0;
            case (pol)
                IPM_POL_FALL_LOW: begin
                    ext_edge[g] = ext_prev[g] & ~ext_level[g];
                    ext_cond[g] = ~ext_level[g];
                end
                IPM_POL_FALL: ext_edge[g] = ext_prev[g] & ~ext_level[g];
                IPM_POL_RISE: ext_edge[g] = ~ext_prev[g] & ext_level[g];
                default: ext_edge[g] = ext_prev[g] ^ ext_level[g];
            endcase
        end
    end

    // register write decoding and polarity change detection
    always_comb begin
        next_misc = misc;
        pol_clear = 4'h0;
        if (ap_valid && ap_write && ap_addr == IPM_MISC_ADDR) begin
            next_misc = hwdata[7:0];
            if (next_misc[IPM_POL_LO_POS +: 2] != misc[IPM_POL_LO_POS +: 2]) begin
                pol_clear[1:0] = 2'h3;
            end
            if (next_misc[IPM_POL_HI_POS +: 2] != misc[IPM_POL_HI_POS +: 2]) begin
                pol_clear[3:2] = 2'h3;
            end
        end
    end

    assign any_ext = |(ext_pend | ext_cond);
    assign any_per = |per_req;

    // bus address phase capture; the slave is always ready and okay
    always_ff @(posedge clk) begin
        if (reset) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 32'h0000_0000;
        end else if (clk_en && hready) begin
            ap_valid <= hsel & htrans[1];
            ap_write <= hwrite;
            ap_addr <= haddr;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            misc <= IPM_MISC_RESET;
        end else if (clk_en) begin
            misc <= next_misc;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            if (hsel && htrans[1] && !hwrite && hready) begin
                case (haddr)
                    IPM_MISC_ADDR: hrdata <= {24'h000000, next_misc};
                    IPM_CTRL_ADDR: hrdata <= {31'h0, condition_code_reg_i};
                    IPM_STAT_ADDR: hrdata <= {20'h0, per_req, ext_pend, 1'b0, 3'(state)};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // external pending latches; a new edge wins over any clear
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_prev <= 4'hF;
            ext_pend <= 4'h0;
        end else if (clk_en && state != IPM_HALT) begin
            ext_prev <= ext_level;
            for (int g = 0; g < 4; g++) begin
                if (ext_edge[g]) begin
                    ext_pend[g] <= 1'b1;
                end else if (pol_clear[g]) begin
                    ext_pend[g] <= 1'b0;
                end else if (irq_take && irq_vector == IPM_VEC_EXT0 - 16'(2 * g)) begin
                    ext_pend[g] <= 1'b0;
                end
            end
        end else if (clk_en) begin
            // halt keeps watching pins so external groups can wake the part
            for (int g = 0; g < 4; g++) begin
                if (ext_edge[g]) begin
                    ext_pend[g] <= 1'b1;
                end
            end
            ext_prev <= ext_level;
        end
    end

    // prioritised vector select and mode sequencing
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= IPM_RUN;
            condition_code_reg_i <= 1'b1;
            irq_take <= 1'b0;
            irq_vector <= IPM_VEC_RESET;
            push_context <= 1'b0;
            core_stall <= 1'b0;
            watchdog_reset <= 1'b0;
            osc_enable <= 1'b1;
            stab_cnt <= '0;
        end else if (clk_en) begin
            irq_take <= 1'b0;
            push_context <= 1'b0;
            watchdog_reset <= 1'b0;
            case (state)
                IPM_RUN: begin
                    core_stall <= 1'b0;
                    if (irq_return_instr) begin
                        condition_code_reg_i <= 1'b0;
                    end else if (instr_end && trap_instr) begin
                        irq_vector <= IPM_VEC_TRAP;
                        push_context <= 1'b1;
                        core_stall <= 1'b1;
                        state <= IPM_STACK;
                    end else if (instr_end && !mask && (any_ext || any_per)) begin
                        push_context <= 1'b1;
                        core_stall <= 1'b1;
                        state <= IPM_STACK;
                        if (ext_pend[0] || ext_cond[0]) irq_vector <= IPM_VEC_EXT0;
                        else if (ext_pend[1] || ext_cond[1]) irq_vector <= IPM_VEC_EXT0 - 16'h2;
                        else if (ext_pend[2] || ext_cond[2]) irq_vector <= IPM_VEC_EXT0 - 16'h4;
                        else if (ext_pend[3] || ext_cond[3]) irq_vector <= IPM_VEC_EXT0 - 16'h6;
                        else if (per_req[0]) irq_vector <= IPM_VEC_SPI;
                        else if (per_req[1]) irq_vector <= IPM_VEC_TIMA;
                        else if (per_req[2]) irq_vector <= IPM_VEC_TIMB;
                        else irq_vector <= IPM_VEC_SCI;
                    end else if (instr_end && wait_for_irq_instr) begin
                        condition_code_reg_i <= 1'b0;
                        core_stall <= 1'b1;
                        state <= IPM_WAIT;
                    end else if (instr_end && halt_instr) begin
                        if (watchdog_enabled) begin
                            watchdog_reset <= 1'b1;
                        end else begin
                            condition_code_reg_i <= 1'b0;
                            osc_enable <= 1'b0;
                            core_stall <= 1'b1;
                            state <= IPM_HALT;
                        end
                    end
                end
                IPM_STACK: begin
                    // mask goes up after context is pushed, in the same cycle as the vector fetch (irq_take)
                    if (stack_done) begin
                        condition_code_reg_i <= 1'b1;
                        irq_take <= 1'b1;
                        core_stall <= 1'b0;
                        state <= IPM_RUN;
                    end
                end
                IPM_WAIT: begin
                    if (any_ext || any_per) begin
                        state <= IPM_RUN;
                        core_stall <= 1'b0;
                    end
                end
                IPM_HALT: begin
                    if (any_ext) begin
                        osc_enable <= 1'b1;
                        stab_cnt <= SCW'(STAB_COUNT);
                        state <= IPM_STAB;
                    end
                end
                IPM_STAB: begin
                    if (stab_cnt <= SCW'(1)) begin
                        core_stall <= 1'b0;
                        state <= IPM_RUN;
                    end else begin
                        stab_cnt <= stab_cnt - SCW'(1);
                    end
                end
                default: state <= IPM_RUN;
            endcase
        end
    end

    // reset seen after wake is taken by the system reset itself
    always_ff @(posedge clk) begin
        if (reset) begin
            wake_by_reset <= 1'b0;
        end
    end

    // oscillator divider; tick marks each cpu clock period
    always_comb begin
        div_max = 5'd1;
        if (misc[IPM_SLOW_POS]) begin
            case (misc[IPM_DIV_POS +: 2])
                2'h0: div_max = 5'd3;
                2'h1: div_max = 5'd15;
                2'h2: div_max = 5'd7;
                default: div_max = 5'd31;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            div_cnt <= 5'h00;
            cpu_clk_tick <= 1'b0;
            cpu_clk_level <= 1'b0;
        end else if (clk_en && osc_enable && osc_clk_level) begin
            cpu_clk_tick <= (div_cnt >= div_max);
            div_cnt <= (div_cnt >= div_max) ? 5'h00 : div_cnt + 5'h01;
            cpu_clk_level <= (div_cnt <= (div_max >> 1));
        end else if (clk_en) begin
            cpu_clk_tick <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            port_f_pin_zero_out <= 1'b0;
            port_f_pin_zero_oe_n <= 1'b1;
        end else if (clk_en) begin
            port_f_pin_zero_out <= cpu_clk_level;
            port_f_pin_zero_oe_n <= ~misc[IPM_CLKOUT_POS];
        end
    end
endmodule : ipm_ctrl
`default_nettype wire

// File: tb/ipm_core_model.sv
// far-side core model that pushes the context after a short or a long delay
`timescale 1ns/1ns
`default_nettype none
module ipm_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stacking handshake
    input wire logic push_context,
    input wire logic slow,
    output logic stack_done
);
    logic [3:0] left;
    logic busy;
    // slow mode stretches the push so the controller must wait for a late answer
    always_ff @(posedge clk) begin
        if (reset) begin
            busy <= 1'h0;
            left <= 4'h0;
            stack_done <= 1'h0;
        end else begin
            stack_done <= busy && left == 4'h0;
            if (push_context) begin
                busy <= 1'h1;
                left <= slow ? 4'h9 : 4'h4;
            end else if (busy && left == 4'h0) begin
                busy <= 1'h0;
            end else if (busy) begin
                left <= left - 4'h1;
            end
        end
    end
endmodule : ipm_core_model
`default_nettype wire

// File: tb/ipm_ctrl_assertions.sv
// concurrent checks on the interrupt and power mode controller ports
`timescale 1ns/1ns
`default_nettype none
module ipm_ctrl_assertions
    import ipm_pkg::*;
#(
    parameter int STAB_COUNT = IPM_STAB_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // core sequencer
    input wire logic instr_end,
    input wire logic trap_instr,
    input wire logic irq_return_instr,
    input wire logic wait_for_irq_instr,
    input wire logic halt_instr,
    input wire logic watchdog_enabled,
    input wire logic stack_done,
    input wire logic condition_code_reg_i,
    input wire logic irq_take,
    input wire logic [15:0] irq_vector,
    input wire logic core_stall,
    input wire logic push_context,
    input wire logic watchdog_reset,
    // oscillator
    input wire logic osc_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // starts full at reset so only a halt exit is timed
    int stab_cnt;
    always_ff @(posedge clk) begin
        if (reset)
            stab_cnt <= STAB_COUNT;
        else if (!osc_enable)
            stab_cnt <= 0;
        else if (stab_cnt < STAB_COUNT)
            stab_cnt <= stab_cnt + 1;
    end
    AST_RESET_STATE: assert property ($fell(reset) |-> condition_code_reg_i)
        else $error("mask clear after reset");
    AST_MASK_GATES: assert property ($rose(push_context) && !$past(trap_instr)
        |-> !$past(condition_code_reg_i)) else $error("request taken while masked");
    AST_PUSH_STALL: assert property ($rose(push_context) |-> core_stall)
        else $error("context push without stall");
    AST_TAKE_MASK: assert property (stack_done && core_stall |=> irq_take && condition_code_reg_i)
        else $error("vector load missing or mask clear");
    AST_TRAP_VEC: assert property ($rose(push_context) && $past(trap_instr)
        |-> irq_vector == IPM_VEC_TRAP) else $error("trap vector wrong");
    AST_RETURN: assert property (irq_return_instr && !core_stall |=> !condition_code_reg_i)
        else $error("mask kept after return");
    AST_WAIT: assert property (instr_end && wait_for_irq_instr && !core_stall
        |=> !condition_code_reg_i) else $error("mask kept in wait");
    AST_HALT: assert property (instr_end && halt_instr && !watchdog_enabled && !core_stall
        |=> !osc_enable && !condition_code_reg_i) else $error("halt entry wrong");
    AST_HALT_WDOG: assert property (instr_end && halt_instr && watchdog_enabled && !core_stall
        |=> watchdog_reset && osc_enable) else $error("halt with watchdog not refused");
    AST_STAB: assert property ($fell(core_stall) |-> stab_cnt >= STAB_COUNT - 1)
        else $error("core released before stabilisation");
endmodule : ipm_ctrl_assertions
bind ipm_ctrl ipm_ctrl_assertions #(.STAB_COUNT(STAB_COUNT)) u_chk (.clk, .reset, .instr_end,
    .trap_instr, .irq_return_instr, .wait_for_irq_instr, .halt_instr, .watchdog_enabled,
    .stack_done, .condition_code_reg_i, .irq_take, .irq_vector, .core_stall, .push_context,
    .watchdog_reset, .osc_enable);
`default_nettype wire

// File: tb/ipm_ctrl_tb_top.sv
// self-checking bench for the interrupt and power mode controller
`timescale 1ns/1ns
`default_nettype none
module ipm_ctrl_tb_top;
    import ipm_pkg::*;
    localparam int STAB = 8;
    logic clk, reset, clk_en, hsel, hwrite, hreadyout, hresp, slow;
    logic [31:0] haddr, hwdata, hrdata, rdq;
    logic [1:0] htrans, spi_flags, spi_enables;
    logic [2:0] hsize, ext_group_one;
    logic instr_end, trap_instr, irq_return_instr, wait_for_irq_instr, halt_instr;
    logic watchdog_enabled, stack_done, condition_code_reg_i, irq_take, core_stall;
    logic push_context, watchdog_reset, osc_clk_level, osc_enable, cpu_clk_tick, cpu_clk_level;
    logic port_f_pin_zero_out, port_f_pin_zero_oe_n;
    logic [15:0] irq_vector;
    logic [3:0] ext_group_zero, ext_group_two, ext_group_three;
    logic [4:0] tima_flags, tima_enables, timb_flags, timb_enables, sci_flags, sci_enables;
    int num_errors, check_count;
    ipm_ctrl #(.STAB_COUNT(STAB)) i_dut (.clk, .reset, .clk_en, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .instr_end,
        .trap_instr, .irq_return_instr, .wait_for_irq_instr, .halt_instr, .watchdog_enabled,
        .stack_done, .condition_code_reg_i, .irq_take, .irq_vector, .core_stall, .push_context,
        .watchdog_reset, .ext_group_zero, .ext_group_one, .ext_group_two, .ext_group_three,
        .spi_flags, .spi_enables, .tima_flags, .tima_enables, .timb_flags, .timb_enables,
        .sci_flags, .sci_enables, .osc_clk_level, .osc_enable, .cpu_clk_tick, .cpu_clk_level,
        .port_f_pin_zero_out, .port_f_pin_zero_oe_n);
    ipm_core_model i_core (.clk, .reset, .push_context, .slow, .stack_done);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'h1, 2'h2, wr, a};
        do @(posedge clk); while (hreadyout !== 1'h1);
        {hsel, htrans, hwdata} <= {1'h0, 2'h0, d};
        do @(posedge clk); while (hreadyout !== 1'h1);
        rdq = hrdata;
    endtask : ahb
    // instruction pulses at a boundary: 0 trap, 1 return, 2 wait, 3 halt
    task automatic instr(input int k);
        @(posedge clk);
        {halt_instr, wait_for_irq_instr, irq_return_instr, trap_instr} <= 4'h1 << k;
        @(posedge clk);
        {halt_instr, wait_for_irq_instr, irq_return_instr, trap_instr} <= 4'h0;
        @(posedge clk);
    endtask : instr
    task automatic take(input logic [15:0] vec);
        int n;
        for (n = 0; n < 300 && push_context !== 1'h1; n++)
            @(posedge clk);
        chk({push_context, irq_vector}, {1'h1, vec});
        for (n = 0; n < 300 && irq_take !== 1'h1; n++)
            @(posedge clk);
        chk({irq_take, condition_code_reg_i}, 2'h3);
    endtask : take
    task automatic quiet(input int n);
        logic seen;
        seen = 1'h0;
        repeat (n) @(posedge clk) seen = seen | push_context;
        chk(seen, 1'h0);
    endtask : quiet
    task automatic ret;
        instr(1);
        chk(condition_code_reg_i, 1'h0);
    endtask : ret
    task automatic mask_on;
        instr(0);
        take(IPM_VEC_TRAP);
    endtask : mask_on
    task automatic t_regs;
        int n;
        int dv [5] = '{2, 4, 16, 8, 32};
        ahb(1'h0, IPM_MISC_ADDR, 32'h0);
        chk(rdq, 32'h0);
        ahb(1'h0, 32'h40, 32'h0);
        chk(rdq, 32'h0);
        ahb(1'h1, IPM_MISC_ADDR, 32'hFF);
        ahb(1'h0, IPM_MISC_ADDR, 32'h0);
        chk({rdq, port_f_pin_zero_oe_n}, {32'hFF, 1'h0});
        for (int m = 0; m < 5; m++) begin
            ahb(1'h1, IPM_MISC_ADDR, (m == 0) ? 32'h0 : 32'((m - 1) * 2 + 1));
            for (n = 0; n < 70 && cpu_clk_tick !== 1'h1; n++)
                @(posedge clk);
            @(posedge clk);
            for (n = 1; n < 70 && cpu_clk_tick !== 1'h1; n++)
                @(posedge clk);
            chk(n, dv[m]);
        end
        ahb(1'h1, IPM_MISC_ADDR, 32'h0);
        repeat (2) @(posedge clk);
        chk(port_f_pin_zero_oe_n, 1'h1);
    endtask : t_regs
    task automatic t_ext;
        logic [1:0] md [9] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h1};
        logic [3:0] st [9] = '{4'hF, 4'hF, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 4'hF, 4'hC};
        logic [3:0] en [9] = '{4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 4'h0, 4'hF, 4'hE, 4'hE};
        logic ex [9] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
        for (int i = 0; i < 9; i++) begin
            mask_on();
            ext_group_zero <= st[i];
            ahb(1'h1, IPM_MISC_ADDR, {27'h0, ~md[i], 3'h0});
            ahb(1'h1, IPM_MISC_ADDR, {27'h0, md[i], 3'h0});
            ret();
            ext_group_zero <= en[i];
            if (ex[i])
                take(IPM_VEC_EXT0);
            else
                quiet(20);
        end
    endtask : t_ext
    task automatic t_periph;
        slow <= 1'h1;
        mask_on();
        {spi_flags, spi_enables, sci_flags, sci_enables} <= {2'h2, 2'h2, 5'h10, 5'h10};
        tima_flags <= 5'h04;
        quiet(10);
        ret();
        take(IPM_VEC_SPI);
        spi_flags <= 2'h0;
        ret();
        take(IPM_VEC_SCI);
        sci_flags <= 5'h00;
        ret();
        quiet(10);
        tima_enables <= 5'h04;
        take(IPM_VEC_TIMA);
        {tima_flags, timb_flags, timb_enables} <= {5'h00, 5'h01, 5'h01};
        ret();
        take(IPM_VEC_TIMB);
        timb_flags <= 5'h00;
        ret();
        slow <= 1'h0;
    endtask : t_periph
    task automatic t_power;
        int n;
        mask_on();
        instr(2);
        chk(condition_code_reg_i, 1'h0);
        quiet(10);
        spi_flags <= 2'h2;
        take(IPM_VEC_SPI);
        spi_flags <= 2'h0;
        ahb(1'h1, IPM_MISC_ADDR, 32'h10);
        watchdog_enabled <= 1'h1;
        instr(3);
        chk({watchdog_reset, osc_enable}, 2'h3);
        watchdog_enabled <= 1'h0;
        instr(3);
        chk({osc_enable, condition_code_reg_i}, 2'h0);
        spi_flags <= 2'h2;
        quiet(20);
        chk(osc_enable, 1'h0);
        ext_group_one <= 3'h3;
        for (n = 0; n < 300 && push_context !== 1'h1; n++)
            @(posedge clk);
        chk(32'(n >= STAB), 32'h1);
        take(IPM_VEC_EXT0 - 16'h2);
        {spi_flags, ext_group_one} <= {2'h0, 3'h7};
        ret();
    endtask : t_power
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset, clk_en, osc_clk_level, instr_end, hsize} = {4'hF, 3'h2};
        {hsel, hwrite, htrans, haddr, hwdata, slow, watchdog_enabled} = '0;
        {trap_instr, irq_return_instr, wait_for_irq_instr, halt_instr} = 4'h0;
        {ext_group_zero, ext_group_one, ext_group_two, ext_group_three} = 15'h7FFF;
        {spi_flags, spi_enables, tima_flags, tima_enables} = '0;
        {timb_flags, timb_enables, sci_flags, sci_enables} = '0;
        num_errors = 0;
        check_count = 0;
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        t_regs();
        t_ext();
        t_periph();
        t_power();
        complete_run();
    end
    initial begin
        #300000;
        num_errors++;
        complete_run();
    end
endmodule : ipm_ctrl_tb_top
`default_nettype wire
